// *** include/sstl_pkg.sv ***
/*
 * Constants for the stop-torque-limit selection and stop sequencing
 * block: register offsets, reset values, codes and timing constants.
 * Assumes a 25 MHz control clock and a plain strobe register port.
 */
`default_nettype none

package sstl_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CFG    = 4'h0;
    localparam logic [3:0] OFS_LIMIT3 = 4'h1;
    localparam logic [3:0] OFS_LIMIT2 = 4'h2;
    localparam logic [3:0] OFS_BRAKE  = 4'h3;
    localparam logic [3:0] OFS_DEVTH  = 4'h4;
    localparam logic [3:0] OFS_OLWARN = 4'h5;
    localparam logic [3:0] OFS_STATUS = 4'h6;
    localparam logic [3:0] OFS_LIMOUT = 4'h7;

    // ------------------------------------------------------------
    // Field positions in the configuration register
    // ------------------------------------------------------------
    localparam int CFG_SRC     = 0;
    localparam int CFG_HOLD    = 1;
    localparam int CFG_SOFF    = 4;
    localparam int CFG_ALARM   = 7;
    localparam int CFG_PLOSS   = 10;
    localparam int CFG_REGEN   = 13;
    localparam int CFG_FLY     = 15;
    localparam int CFG_UV      = 16;

    // ------------------------------------------------------------
    // Stop codes and reset values
    // ------------------------------------------------------------
    localparam logic [2:0]  STOP_FREE      = 3'h3;
    localparam logic [2:0]  STOP_EMERG     = 3'h5;
    localparam logic [2:0]  STOP_MINOR4    = 3'h4;
    localparam logic [8:0]  RST_LIMIT      = 9'h12c;  // 300 %
    localparam logic [9:0]  RST_BRAKE      = 10'h000; // 0.00 s
    localparam logic [9:0]  RST_DEVTH      = 10'h096; // 15.0 rev
    localparam logic [6:0]  RST_OLWARN     = 7'h32;   // 50 %
    // Codes 5 for servo-off, alarm and power loss, undervoltage detect on
    localparam logic [16:0] RST_CFG        = 17'h1_16d0;

    // ------------------------------------------------------------
    // Timing: brake delay counts in 10 ms steps
    // ------------------------------------------------------------
    localparam int  CLK_HZ      = 25_000_000;
    localparam int  TICK_MS     = 10;
    localparam int  TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    typedef enum logic [1:0] {
        SSTL_CTRL_POS,
        SSTL_CTRL_SPD,
        SSTL_CTRL_TRQ
    } sstl_mode_e;

endpackage : sstl_pkg

`default_nettype wire

// *** hw/sstl_tick.sv ***
/*
 * Divider that emits a one-cycle enable every PERIOD clocks.
 * Assumes one clock domain; the enable feeds same-clock logic only.
 */
`default_nettype none

module sstl_tick #(
    parameter int PERIOD = 250_000
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Enable pulse
    output logic      tick
);
    logic [31:0] count;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 32'h0;
            tick  <= 1'b0;
        end else if (count == 32'(PERIOD - 1)) begin
            count <= 32'h0;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick  <= 1'b0;
        end
    end
endmodule : sstl_tick

`default_nettype wire

// *** hw/sstl_top.sv ***
/*
 * Stop torque-limit selection and stop sequencing for a servo drive.
 * Picks the torque limit during controlled stops in position and speed modes and for deviation
 * hold, sequences brake and free-run after servo-off, flags flying
 * start, undervoltage, deviation overflow and overload warning.
 * Assumes terminal inputs are asynchronous pins; limit values,
 * speed, deviation and overload level come from same-clock logic.
 */
`default_nettype none

module sstl_top
    import sstl_pkg::*;
#(
    parameter int TICK_PERIOD = sstl_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // Register port
    input  wire logic [3:0] ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [31:0] RDATA,
    // Digital input terminals (pins)
    input  wire logic       SERVO_ON,
    input  wire logic       FORCED_STOP,
    input  wire logic       FWD_OVERTRAVEL,
    input  wire logic       REV_OVERTRAVEL,
    input  wire logic       TL_SEL0,
    input  wire logic       TL_SEL1,
    // Drive state from same-clock logic
    input  wire sstl_pkg::sstl_mode_e CTRL_MODE,
    input  wire logic       DIR_CCW,
    input  wire logic       MINOR_ALARM,
    input  wire logic       MAJOR_ALARM,
    input  wire logic       MAIN_POWER_LOSS,
    input  wire logic       UNDERVOLTAGE,
    input  wire logic       REGEN_OVERHEAT,
    input  wire logic       MOTOR_RUNNING,
    input  wire logic [15:0] MOTOR_SPEED,
    input  wire logic [15:0] DEVIATION_TENTHS,
    input  wire logic [6:0] OVERLOAD_LEVEL,
    input  wire logic [8:0] FWD_LIMIT,
    input  wire logic [8:0] REV_LIMIT,
    input  wire logic signed [9:0] ANALOG_TORQUE_LIMIT,
    // Outputs
    output logic [8:0]      TORQUE_LIMIT,
    output logic [8:0]      HOLD_LIMIT,
    output logic            HOLD_ACTIVE,
    output logic            TORQUE_ENABLE,
    output logic            EMERGENCY_STOP,
    output logic            BRAKE_RELEASE,
    output logic            FLY_START,
    output logic [15:0]     FLY_SPEED,
    output logic            UNDERVOLTAGE_ALARM,
    output logic            REGEN_ALARM,
    output logic            DEVIATION_OVERFLOW,
    output logic            OVERLOAD_WARNING
);
    import sstl_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [8:0] min9(input logic [8:0] a,
                                        input logic [8:0] b);
        return (a < b) ? a : b;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers: change accepted when stages 2 and 3 agree
    // ------------------------------------------------------------
    localparam int NPIN = 6;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    logic [NPIN-1:0] pin;

    assign pin_raw = {TL_SEL1, TL_SEL0, REV_OVERTRAVEL, FWD_OVERTRAVEL,
                      FORCED_STOP, SERVO_ON};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pin   <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < NPIN; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin[i] <= sync3[i];
                end
            end
        end
    end

    logic servo_on;
    logic fstop_ok;
    logic fot_ok;
    logic rot_ok;
    logic sel0;
    logic sel1;
    assign {sel1, sel0, rot_ok, fot_ok, fstop_ok, servo_on} = pin;

    // ------------------------------------------------------------
    // Registers: live settings and power-on copies
    // ------------------------------------------------------------
    logic [16:0] cfg;
    logic [16:0] cfg_live;
    logic [8:0]  limit3;
    logic [8:0]  limit2;
    logic [9:0]  brake_delay;
    logic [9:0]  dev_th;
    logic [6:0]  ol_warn;
    logic        cfg_taken;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_live    <= RST_CFG;
            limit3      <= RST_LIMIT;
            limit2      <= RST_LIMIT;
            brake_delay <= RST_BRAKE;
            dev_th      <= RST_DEVTH;
            ol_warn     <= RST_OLWARN;
        end else if (WR) begin
            if (ADDR == OFS_CFG) begin
                cfg_live <= WDATA[16:0];
            end else if (ADDR == OFS_LIMIT3) begin
                limit3 <= WDATA[8:0];
            end else if (ADDR == OFS_LIMIT2) begin
                limit2 <= WDATA[8:0];
            end else if (ADDR == OFS_BRAKE) begin
                brake_delay <= WDATA[9:0];
            end else if (ADDR == OFS_DEVTH) begin
                dev_th <= WDATA[9:0];
            end else if (ADDR == OFS_OLWARN) begin
                ol_warn <= WDATA[6:0];
            end
        end
    end

    // Power-on settings take the live copy once after reset release;
    // later writes stay in cfg_live only, and the next reset reloads RST_CFG into both.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg       <= RST_CFG;
            cfg_taken <= 1'b0;
        end else if (!cfg_taken) begin
            cfg       <= cfg_live;
            cfg_taken <= 1'b1;
        end
    end

    logic       src_analog;
    logic [1:0] hold_sel;
    logic [2:0] soff_code;
    logic [2:0] alarm_code;
    logic [2:0] ploss_code;
    logic [1:0] regen_code;
    logic       fly_en;
    logic       uv_en;
    assign src_analog = cfg[CFG_SRC];
    assign hold_sel   = cfg[CFG_HOLD +: 2];
    assign soff_code  = cfg[CFG_SOFF +: 3];
    assign alarm_code = cfg[CFG_ALARM +: 3];
    assign ploss_code = cfg[CFG_PLOSS +: 3];
    assign regen_code = cfg_live[CFG_REGEN +: 2];
    assign fly_en     = cfg[CFG_FLY];
    assign uv_en      = cfg[CFG_UV];

    // ------------------------------------------------------------
    // Stop torque-limit selection
    // ------------------------------------------------------------
    logic [8:0] analog_lim;
    logic [8:0] dir_lim;
    logic [8:0] stop_lim;
    logic       stop_cause;
    logic       pos_or_spd;

    // Negative input gives no usable limit
    assign analog_lim = ANALOG_TORQUE_LIMIT[9] ? 9'h000
                                               : ANALOG_TORQUE_LIMIT[8:0];
    assign dir_lim    = DIR_CCW ? REV_LIMIT : FWD_LIMIT;
    assign pos_or_spd = (CTRL_MODE == SSTL_CTRL_POS)
                     || (CTRL_MODE == SSTL_CTRL_SPD);
    assign stop_cause = !servo_on || !fstop_ok || !fot_ok || !rot_ok
                     || (MINOR_ALARM && (alarm_code == STOP_MINOR4
                                      || alarm_code == STOP_EMERG));

    always_comb begin
        stop_lim = dir_lim;
        case ({sel1, sel0})
            2'b00: stop_lim = (dir_lim >= limit3) ? limit3 : dir_lim;
            2'b01: stop_lim = (analog_lim >= limit3 && dir_lim >= limit3)
                            ? limit3 : min9(analog_lim, dir_lim);
            2'b10: stop_lim = (limit2 >= limit3 && dir_lim >= limit3)
                            ? limit3 : min9(limit2, dir_lim);
            default: stop_lim = (analog_lim >= limit3 && limit2 >= limit3)
                            ? limit3 : min9(analog_lim, limit2);
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TORQUE_LIMIT <= 9'h000;
        end else if (src_analog) begin
            TORQUE_LIMIT <= analog_lim;
        end else if (pos_or_spd && stop_cause) begin
            TORQUE_LIMIT <= stop_lim;
        end else begin
            TORQUE_LIMIT <= dir_lim;
        end
    end

    // ------------------------------------------------------------
    // Deviation hold at torque limit
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            HOLD_ACTIVE <= 1'b0;
            HOLD_LIMIT  <= 9'h000;
        end else if (CTRL_MODE != SSTL_CTRL_POS) begin
            HOLD_ACTIVE <= 1'b0;
            HOLD_LIMIT  <= 9'h000;
        end else if (hold_sel == 2'd2 && (sel0 || src_analog)) begin
            HOLD_ACTIVE <= 1'b1;
            HOLD_LIMIT  <= analog_lim;
        end else if (hold_sel == 2'd1 && sel1 && !src_analog) begin
            HOLD_ACTIVE <= 1'b1;
            HOLD_LIMIT  <= limit2;
        end else begin
            HOLD_ACTIVE <= 1'b0;
            HOLD_LIMIT  <= 9'h000;
        end
    end

    // ------------------------------------------------------------
    // Servo-off, alarm and power-loss stop sequencing
    // ------------------------------------------------------------
    logic       tick;
    logic [9:0] hold_count;
    logic       servo_on_d;
    logic       free_run;

    sstl_tick #(
        .PERIOD (TICK_PERIOD)
    ) u_tick (
        .clk    (CLK),
        .rst_n  (RST_N),
        .tick   (tick)
    );

    logic [2:0] act_code;
    logic       stop_req;
    always_comb begin
        act_code = soff_code;
        stop_req = !servo_on;
        if (MAIN_POWER_LOSS) begin
            act_code = ploss_code;
            stop_req = 1'b1;
        end else if (MAJOR_ALARM) begin
            act_code = STOP_FREE;
            stop_req = 1'b1;
        end else if (MINOR_ALARM) begin
            act_code = alarm_code;
            stop_req = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            servo_on_d     <= 1'b0;
            hold_count     <= 10'h000;
            TORQUE_ENABLE  <= 1'b0;
            EMERGENCY_STOP <= 1'b0;
            BRAKE_RELEASE  <= 1'b0;
            free_run       <= 1'b1;
        end else begin
            servo_on_d    <= servo_on;
            BRAKE_RELEASE <= servo_on && !stop_req;
            if (!stop_req) begin
                hold_count     <= brake_delay;
                TORQUE_ENABLE  <= 1'b1;
                EMERGENCY_STOP <= 1'b0;
                free_run       <= 1'b0;
            end else if (act_code == STOP_FREE) begin
                TORQUE_ENABLE  <= 1'b0;
                EMERGENCY_STOP <= 1'b0;
                free_run       <= 1'b1;
            end else if (MOTOR_RUNNING && !free_run) begin
                TORQUE_ENABLE  <= 1'b1;
                EMERGENCY_STOP <= 1'b1;
                if (tick && hold_count != 10'h000) begin
                    hold_count <= hold_count - 10'h001;
                end
            end else if (hold_count != 10'h000) begin
                EMERGENCY_STOP <= 1'b0;
                if (tick) begin
                    hold_count <= hold_count - 10'h001;
                end
            end else begin
                TORQUE_ENABLE  <= 1'b0;
                EMERGENCY_STOP <= 1'b0;
                free_run       <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Flying start: on a rising edge of synchronised servo-on, including the first one after reset
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            FLY_START <= 1'b0;
            FLY_SPEED <= 16'h0000;
        end else begin
            FLY_START <= 1'b0;
            if (fly_en && CTRL_MODE == SSTL_CTRL_SPD && cfg_taken
                && servo_on && !servo_on_d && free_run
                && MOTOR_RUNNING) begin
                FLY_START <= 1'b1;
                FLY_SPEED <= MOTOR_SPEED;
            end
        end
    end
    // servo_on_d resets low and the synchroniser settles low, so the
    // first edge after power-up can catch a running motor in free-run

    // ------------------------------------------------------------
    // Alarms and warnings
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            UNDERVOLTAGE_ALARM <= 1'b0;
            REGEN_ALARM        <= 1'b0;
            DEVIATION_OVERFLOW <= 1'b0;
            OVERLOAD_WARNING   <= 1'b0;
        end else begin
            UNDERVOLTAGE_ALARM <= uv_en && UNDERVOLTAGE;
            REGEN_ALARM        <= (regen_code == 2'd1)
                               && REGEN_OVERHEAT;
            DEVIATION_OVERFLOW <= (dev_th != 10'h000)
                               && (DEVIATION_TENTHS > {6'h00, dev_th});
            OVERLOAD_WARNING   <= (OVERLOAD_LEVEL >= ol_warn);
        end
    end

    // ------------------------------------------------------------
    // Register read port, data one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 32'h0;
        end else if (RD) begin
            if (ADDR == OFS_CFG) begin
                RDATA <= {15'h0, cfg_live};
            end else if (ADDR == OFS_LIMIT3) begin
                RDATA <= {23'h0, limit3};
            end else if (ADDR == OFS_LIMIT2) begin
                RDATA <= {23'h0, limit2};
            end else if (ADDR == OFS_BRAKE) begin
                RDATA <= {22'h0, brake_delay};
            end else if (ADDR == OFS_DEVTH) begin
                RDATA <= {22'h0, dev_th};
            end else if (ADDR == OFS_OLWARN) begin
                RDATA <= {25'h0, ol_warn};
            end else if (ADDR == OFS_STATUS) begin
                RDATA <= {24'h0, free_run, EMERGENCY_STOP, TORQUE_ENABLE,
                          BRAKE_RELEASE, UNDERVOLTAGE_ALARM, REGEN_ALARM,
                          DEVIATION_OVERFLOW, OVERLOAD_WARNING};
            end else if (ADDR == OFS_LIMOUT) begin
                RDATA <= {23'h0, TORQUE_LIMIT};
            end else begin
                RDATA <= 32'h0;
            end
        end else begin
            RDATA <= 32'h0;
        end
    end
endmodule : sstl_top

`default_nettype wire

// *** tb/sstl_asserts.sv ***
/* Port checker for sstl_top, bound into it.
   Assumes the undervoltage enable bit is never cleared. */
`default_nettype none
module sstl_asserts
    import sstl_pkg::*;
#(
    parameter int TICK_PERIOD = 4
) (
    // Clock, reset and register port
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic [3:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    // Drive state
    input wire logic        SERVO_ON,
    input wire sstl_pkg::sstl_mode_e CTRL_MODE,
    input wire logic        DIR_CCW,
    input wire logic [8:0]  FWD_LIMIT,
    input wire logic [8:0]  REV_LIMIT,
    input wire logic        UNDERVOLTAGE,
    input wire logic        REGEN_OVERHEAT,
    input wire logic [15:0] DEVIATION_TENTHS,
    input wire logic [6:0]  OVERLOAD_LEVEL,
    // Outputs watched
    input wire logic [8:0]  TORQUE_LIMIT,
    input wire logic        BRAKE_RELEASE,
    input wire logic        UNDERVOLTAGE_ALARM,
    input wire logic        REGEN_ALARM,
    input wire logic        DEVIATION_OVERFLOW,
    input wire logic        OVERLOAD_WARNING
);
    logic [16:0] cfg;
    logic [9:0]  th;
    logic [6:0]  olw;
    // Shadow of the live settings
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg <= RST_CFG;
            th  <= RST_DEVTH;
            olw <= RST_OLWARN;
        end else if (WR) begin
            if (ADDR == OFS_CFG) cfg <= WDATA[16:0];
            if (ADDR == OFS_DEVTH) th <= WDATA[9:0];
            if (ADDR == OFS_OLWARN) olw <= WDATA[6:0];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    chk_brake_drop: assert property ($fell(SERVO_ON)
        |-> ##[1:6] !BRAKE_RELEASE) else $error("brake not dropped");
    chk_olw_set: assert property ((OVERLOAD_LEVEL >= olw)[*2]
        |-> OVERLOAD_WARNING) else $error("overload warning missing");
    chk_olw_clear: assert property ((OVERLOAD_LEVEL < olw)[*2]
        |-> !OVERLOAD_WARNING) else $error("overload warning early");
    chk_dev_ovf: assert property (
        (th != 10'h0 && DEVIATION_TENTHS > {6'h0, th})[*2]
        |-> DEVIATION_OVERFLOW) else $error("deviation overflow missing");
    chk_regen_off: assert property ((cfg[14:13] != 2'h1)[*2]
        |-> !REGEN_ALARM) else $error("regen alarm not suppressed");
    chk_regen_on: assert property (
        (cfg[14:13] == 2'h1 && REGEN_OVERHEAT)[*2]
        |-> REGEN_ALARM) else $error("regen alarm missing");
    chk_uv_alarm: assert property (UNDERVOLTAGE[*2]
        |-> UNDERVOLTAGE_ALARM) else $error("undervoltage alarm missing");
    chk_trq_mode: assert property ((CTRL_MODE == SSTL_CTRL_TRQ
        && $stable(FWD_LIMIT) && $stable(REV_LIMIT) && $stable(DIR_CCW))[*3]
        |-> TORQUE_LIMIT == (DIR_CCW ? REV_LIMIT : FWD_LIMIT))
        else $error("third limit used in torque mode");
endmodule // sstl_asserts
bind sstl_top sstl_asserts #(.TICK_PERIOD(TICK_PERIOD)) u_chk (.*);
`default_nettype wire

// *** tb/sstl_ctrl_model.sv ***
/* Motion controller at the terminals, with a slow mechanical brake.
   Assumes the bench supplies terminal commands on the drive clock. */
`default_nettype none
module sstl_ctrl_model #(
    parameter int MECH = 4
) (
    input  wire logic       clk,
    input  wire logic [5:0] cmd,
    input  wire logic       brake_release,
    output logic      [5:0] pins,
    output logic            brake_engaged
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    always_ff @(posedge clk) pins <= cmd;
    // Brake grips MECH cycles after release drops; delay must exceed it
    always_ff @(posedge clk) begin
        if (brake_release) cnt <= 0;
        else if (cnt < MECH) cnt <= cnt + 1;
    end
    assign brake_engaged = (cnt == MECH);
endmodule // sstl_ctrl_model
`default_nettype wire

// *** tb/sstl_top_bench.sv ***
/* Self-checking bench for sstl_top.
   Assumes the checker is bound in from its own file. */
`default_nettype none
module sstl_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import sstl_pkg::*;
    logic CLK = 0, RST_N = 0, WR = 0, RD = 0, DIR_CCW = 0, eng;
    logic MOTOR_RUNNING = 0, UNDERVOLTAGE = 0, REGEN_OVERHEAT = 0;
    logic MINOR_ALARM = 0, MAJOR_ALARM = 0, MAIN_POWER_LOSS = 0;
    logic [3:0] ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [5:0] cmd = 6'h0, pins;
    logic [15:0] DEVIATION_TENTHS = 16'h0, MOTOR_SPEED = 16'h0;
    logic [6:0] OVERLOAD_LEVEL = 7'h0;
    logic [8:0] FWD_LIMIT = 9'h0c8, REV_LIMIT = 9'h0b4, TORQUE_LIMIT;
    logic signed [9:0] ANALOG_TORQUE_LIMIT = -10'sd10;
    logic TORQUE_ENABLE, BRAKE_RELEASE, UNDERVOLTAGE_ALARM, REGEN_ALARM;
    logic DEVIATION_OVERFLOW, OVERLOAD_WARNING;
    sstl_mode_e CTRL_MODE = SSTL_CTRL_POS;
    int num_errors = 0, n_checks = 0;
    sstl_top #(.TICK_PERIOD(4)) dut (.*, .SERVO_ON(pins[0]),
        .FORCED_STOP(pins[1]), .FWD_OVERTRAVEL(pins[2]),
        .REV_OVERTRAVEL(pins[3]), .TL_SEL0(pins[4]), .TL_SEL1(pins[5]),
        .HOLD_LIMIT(), .HOLD_ACTIVE(), .EMERGENCY_STOP(), .FLY_START(),
        .FLY_SPEED());
    sstl_ctrl_model ctrl (.clk(CLK), .cmd(cmd), .pins(pins),
        .brake_release(BRAKE_RELEASE), .brake_engaged(eng));
    always #20 CLK = ~CLK;
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 v = RDATA;
    endtask
    task automatic t_regs();
        logic [3:0] a [7] = '{OFS_CFG, OFS_LIMIT3, OFS_LIMIT2, OFS_BRAKE,
                              OFS_DEVTH, OFS_OLWARN, 4'hc};
        logic [31:0] e [7] = '{32'(RST_CFG), 32'(RST_LIMIT), 32'(RST_LIMIT),
            32'(RST_BRAKE), 32'(RST_DEVTH), 32'(RST_OLWARN), 32'h0};
        logic [31:0] v;
        for (int i = 0; i < 7; i++) begin
            rd(a[i], v);
            chk("reg", e[i], v);
        end
    endtask
    // One controlled stop: selects, stop cause bit, limits, expected limit
    task automatic t_stop(input logic [1:0] sel, input int cause,
        input logic [8:0] t3, l2, input logic ccw, input sstl_mode_e m,
        input logic [8:0] e);
        wr(OFS_LIMIT3, 32'(t3));
        wr(OFS_LIMIT2, 32'(l2));
        DIR_CCW <= ccw;
        CTRL_MODE <= m;
        cmd <= {sel, 4'hf};
        repeat (8) @(posedge CLK);
        MOTOR_RUNNING <= 1'b1;
        cmd <= {sel, 4'hf} & ~(6'h1 << cause);
        repeat (8) @(posedge CLK);
        #1 chk("stop_limit", 32'(e), 32'(TORQUE_LIMIT));
        MOTOR_RUNNING <= 1'b0;
        cmd <= 6'h0f;
        repeat (8) @(posedge CLK);
    endtask
    // Output is picked after the wait so the settled value is judged
    task automatic lvl(input string nm, input logic e, input int w);
        logic g;
        repeat (4) @(posedge CLK);
        #1;
        case (w)
            0: g = OVERLOAD_WARNING;
            1: g = DEVIATION_OVERFLOW;
            2: g = UNDERVOLTAGE_ALARM;
            default: g = REGEN_ALARM;
        endcase
        chk(nm, 32'(e), 32'(g));
    endtask
    task automatic t_levels();
        OVERLOAD_LEVEL <= 7'd49;
        lvl("olwarn", 1'b0, 0);
        OVERLOAD_LEVEL <= 7'd50;
        lvl("olwarn", 1'b1, 0);
        DEVIATION_TENTHS <= 16'd150;
        lvl("devovf", 1'b0, 1);
        DEVIATION_TENTHS <= 16'd151;
        lvl("devovf", 1'b1, 1);
        UNDERVOLTAGE <= 1'b1;
        lvl("uv", 1'b1, 2);
        REGEN_OVERHEAT <= 1'b1;
        lvl("regen", 1'b0, 3);
        wr(OFS_CFG, 32'(RST_CFG) | 32'h2000);
        lvl("regen", 1'b1, 3);
        wr(OFS_CFG, 32'(RST_CFG) | 32'h4000);
        lvl("regen", 1'b0, 3);
    endtask
    task automatic t_brake();
        wr(OFS_BRAKE, 32'h3);
        repeat (10) @(posedge CLK);
        #1 chk("brake_on", 32'h1, 32'(BRAKE_RELEASE));
        @(posedge CLK);
        cmd <= 6'h0e;
        for (int i = 0; i < 40 && eng !== 1'b1; i++) @(posedge CLK);
        #1 chk("brake_off", 32'h0, 32'(BRAKE_RELEASE));
        chk("torque_held", 32'h1, 32'(TORQUE_ENABLE));
        repeat (30) @(posedge CLK);
        #1 chk("free_run", 32'h0, 32'(TORQUE_ENABLE));
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge CLK);
        RST_N <= 1'b1;
        t_regs();
        t_stop(2'h0, 1, 150, 300, 0, SSTL_CTRL_POS, 150);
        t_stop(2'h0, 3, 250, 300, 1, SSTL_CTRL_SPD, 180);
        t_stop(2'h2, 2, 250, 120, 0, SSTL_CTRL_POS, 120);
        t_stop(2'h0, 1, 150, 300, 0, SSTL_CTRL_TRQ, 200);
        wr(OFS_CFG, 32'(RST_CFG) | 32'h1);
        t_stop(2'h0, 1, 150, 300, 0, SSTL_CTRL_POS, 150);
        t_levels();
        t_brake();
        // Mid-run reset: outputs clear and settings return to defaults
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        #1 chk("rst_limit", 32'h0, 32'(TORQUE_LIMIT));
        @(posedge CLK);
        RST_N <= 1'b1;
        begin
            logic [31:0] v;
            rd(OFS_CFG, v);
            chk("rst_cfg", 32'(RST_CFG), v);
        end
        test_done();
    end
    initial begin
        repeat (3000) @(posedge CLK);
        num_errors++;
        test_done();
    end
endmodule // sstl_top_bench
`default_nettype wire
